// >>> ssr_pkg.sv
// Shared constants for the synchronous burst SRAM memory end and controller.
package ssr_pkg;
	// Default address width in words.
	localparam int unsigned ADDR_W = 17;
	// Default byte lane count.
	localparam int unsigned LANES = 4;
	// Default bits per byte lane, including parity.
	localparam int unsigned LANE_W = 9;
	// Longest snooze entry latency, in clock cycles.
	localparam int unsigned SLEEP_ENTRY_CYC = 2;
	// Least sleep recovery time, in clock cycles.
	localparam int unsigned SLEEP_RECOVERY_CYC = 2;
	// Width of the small wake and recovery counters.
	localparam int unsigned CNT_W = 2;
	// Reset value of the counters.
	localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
	// Burst offset width: four words per burst.
	localparam int unsigned BURST_W = 2;

	// Memory end power states.
	typedef enum logic [1:0] {
		SSR_AWAKE  = 2'b00,
		SSR_SNOOZE = 2'b01,
		SSR_WAKING = 2'b10
	} ssr_pwr_t;

	// Controller states.
	typedef enum logic [2:0] {
		SSR_IDLE    = 3'b000,
		SSR_RD_ADDR = 3'b001,
		SSR_RD_WAIT = 3'b010,
		SSR_RD_CAPT = 3'b011,
		SSR_WR      = 3'b100,
		SSR_SLEEP   = 3'b101,
		SSR_RECOVER = 3'b110
	} ssr_ctl_st_t;
endpackage

// >>> ssr_if.sv
// Pin bundle joining the SRAM memory end and its controller.
`timescale 1ns/1ps
`default_nettype none
interface ssr_if #(
	parameter int unsigned AW = ssr_pkg::ADDR_W,
	parameter int unsigned NL = ssr_pkg::LANES,
	parameter int unsigned LW = ssr_pkg::LANE_W
);
	logic          sleep_request;                 // High asks for snooze.
	logic          processor_address_strobe_n;    // Low starts an access.
	logic          controller_address_strobe_n;   // Low starts an access.
	logic          burst_advance_n;               // Low steps the burst.
	logic          global_write_strobe_n;         // Low writes all lanes.
	logic          byte_write_gate_n;             // Low enables lane writes.
	logic [NL-1:0] byte_lane_write_n;             // Low writes that lane.
	logic          chip_select_n;                 // Low selects.
	logic          chip_select_high;              // High selects.
	logic          chip_select_b_n;               // Low selects.
	logic          output_enable_n;               // Low lets reads drive.
	logic [AW-1:0] addr;                          // Word address.
	logic [NL*LW-1:0] ctl_dq;                     // Controller data out.
	logic          ctl_dq_oe;                     // Controller drives data.
	logic [NL*LW-1:0] mem_dq;                     // Memory data out.
	logic          mem_dq_oe;                     // Memory drives data.
	logic [NL*LW-1:0] dq;                         // Resolved data wire.

	// The shared data wire carries whichever end drives; idle reads zero.
	assign dq = mem_dq_oe ? mem_dq : (ctl_dq_oe ? ctl_dq : '0);

	// Memory end view.
	modport mem (
		input  sleep_request, processor_address_strobe_n,
		input  controller_address_strobe_n, burst_advance_n,
		input  global_write_strobe_n, byte_write_gate_n, byte_lane_write_n,
		input  chip_select_n, chip_select_high, chip_select_b_n,
		input  output_enable_n, addr, dq,
		output mem_dq, mem_dq_oe
	);

	// Controller end view.
	modport ctl (
		output sleep_request, processor_address_strobe_n,
		output controller_address_strobe_n, burst_advance_n,
		output global_write_strobe_n, byte_write_gate_n, byte_lane_write_n,
		output chip_select_n, chip_select_high, chip_select_b_n,
		output output_enable_n, addr, ctl_dq, ctl_dq_oe,
		input  dq
	);
endinterface
`default_nettype wire

// >>> ssr_mem_end.sv
// Memory end: pipelined burst SRAM with an asynchronous snooze pin.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Snooze takes hold within two clock cycles.
// - Controller waits two cycles after wake request.
// - Sleep pin acts without the clock.
// - Dropping sleep pin resumes normal operation.
// - Array contents kept unchanged during snooze.
// - Pending access at snooze entry is abandoned.
// - Controller deselects before raising sleep pin.
// - Selects and strobes inactive during recovery.
// - Output enable ignored when write sampled low.
// - Address captured on strobe edge when enabled.
// - Selects checked at strobe edges, set enable.
// - Enabled device samples other inputs every edge.
module ssr_mem_end #(
	parameter int unsigned AW = ssr_pkg::ADDR_W,
	parameter int unsigned NL = ssr_pkg::LANES,
	parameter int unsigned LW = ssr_pkg::LANE_W
) (
	input  wire logic ref_clk_i,     // System clock.
	input  wire logic rst_n_i,       // Asynchronous reset, active low.
	ssr_if.mem        pins,          // Pin side toward the controller.
	output logic      snoozing_o,    // High while in snooze or waking.
	output logic      enabled_o      // High while the device is selected.
);
	localparam int unsigned DW = NL * LW;

	// Start value of the wake settle countdown. The test for zero takes
	// an edge of its own, so the load sits one below the cycle figure.
	localparam int unsigned WAKE_LOAD_I = ssr_pkg::SLEEP_RECOVERY_CYC - 1;
	localparam logic [ssr_pkg::CNT_W-1:0] WAKE_LOAD =
		WAKE_LOAD_I[ssr_pkg::CNT_W-1:0];

	// Whole register state of the memory end. The power field runs a
	// small machine: awake serves accesses, snooze holds everything
	// still, and waking lets the array settle before new accesses.
	typedef struct packed {
		ssr_pkg::ssr_pwr_t       pwr;      // Power state.
		logic [ssr_pkg::CNT_W-1:0] cnt;    // Wake countdown.
		logic                    enabled;  // Selected at last strobe.
		logic [AW-1:0]           addr;     // Current burst address.
		logic                    rd_pend;  // Read waits for array stage.
		logic                    out_vld;  // Output stage holds read data.
		logic                    wr_seen;  // Write sampled at last edge.
		logic [DW-1:0]           out_data; // Output stage data.
	} ssr_mem_st_t;

	// All state but the array sits in one packed register; the copy below is filled
	// by the next-state logic and loaded on every clock edge.
	ssr_mem_st_t r_reg;                    // Registered state.
	ssr_mem_st_t r_next;                   // Next state.

	// The array has no reset, so a word never written reads unknown.
	// It is only ever written through the lane write port below.
	logic [DW-1:0] mem_arr [2**AW];        // Storage array.

	// Pin decode for the current cycle, rebuilt every cycle.
	logic          asleep;                 // Snooze in force now.
	logic          strobe;                 // Either address strobe low.
	logic          sel_ok;                 // All three selects asserted.
	logic          en_now;                 // Enabled for this edge.
	logic          wr_any;                 // Some write strobe low.
	logic [NL-1:0] lane_we;                // Lanes written this edge.
	logic          do_wr;                  // Array write on this edge.
	logic [AW-1:0] wr_addr;                // Address written this edge.

	// Input decode, combinational so the sleep pin bypasses the clock.
	always_comb begin
		// Snooze takes hold as soon as the pin rises, with no edge
		// needed, and lasts until the waking state has run out.
		asleep  = pins.sleep_request || (r_reg.pwr != ssr_pkg::SSR_AWAKE);

		// Either address strobe starts a new access at this edge.
		strobe  = !pins.processor_address_strobe_n ||
			!pins.controller_address_strobe_n;
		// The device answers only with all three chip selects valid.
		sel_ok  = !pins.chip_select_n && pins.chip_select_high &&
			!pins.chip_select_b_n;
		// Selects only count at a strobe edge; otherwise enable holds.
		en_now  = strobe ? sel_ok : r_reg.enabled;

		// A write needs the global strobe, or the gate with a lane low.
		wr_any  = !pins.global_write_strobe_n ||
			(!pins.byte_write_gate_n && !(&pins.byte_lane_write_n));

		// Global write takes every lane, else the gated lane strobes.
		if (!pins.global_write_strobe_n) begin
			lane_we = '1;
		end else if (!pins.byte_write_gate_n) begin
			// Lane strobes are active low; invert them into a mask.
			lane_we = ~pins.byte_lane_write_n;
		end else begin
			lane_we = '0;
		end

		// Writes never reach the array in snooze, so contents hold.
		do_wr   = !asleep && en_now && wr_any &&
			pins.processor_address_strobe_n;

		// A strobe edge writes at the new address; later beats of a
		// burst write at the held one.
		wr_addr = strobe ? pins.addr : r_reg.addr;
	end

	// Next-state logic for power, selection and the read pipeline.
	// Only this process writes the copy; the register below loads it.
	always_comb begin
		r_next = r_reg;
		// Power state machine.
		case (r_reg.pwr)
			ssr_pkg::SSR_AWAKE: begin
				// A raised sleep pin at an edge settles the state in snooze.
				if (pins.sleep_request) begin
					r_next.pwr = ssr_pkg::SSR_SNOOZE;
				end
			end
			ssr_pkg::SSR_SNOOZE: begin
				// No write reaches the array here, so its contents stay put.
				// Leave snooze once the pin drops; settle before serving.
				if (!pins.sleep_request) begin
					r_next.pwr = ssr_pkg::SSR_WAKING;
					r_next.cnt = WAKE_LOAD;
				end
			end
			ssr_pkg::SSR_WAKING: begin
				// A new sleep request sends the state straight back to
				// snooze; otherwise the countdown runs out and work resumes.
				if (pins.sleep_request) begin
					r_next.pwr = ssr_pkg::SSR_SNOOZE;
				end else if (r_reg.cnt == ssr_pkg::CNT_RST) begin
					r_next.pwr = ssr_pkg::SSR_AWAKE;
				end else begin
					r_next.cnt = r_reg.cnt - 1'b1;
				end
			end
			default: begin
				// An unused code parks in snooze; the wake path recovers.
				r_next.pwr = ssr_pkg::SSR_SNOOZE;
			end
		endcase

		// While asleep only the sleep pin above is looked at.
		if (asleep) begin
			// Pending accesses are dropped and inputs are not looked at.
			r_next.enabled = 1'b0;
			r_next.rd_pend = 1'b0;
			r_next.out_vld = 1'b0;
			r_next.wr_seen = 1'b0;
		end else begin
			// Selection follows the chip selects at each strobe edge.
			r_next.enabled = en_now;
			// A sampled write keeps the read drivers off next cycle,
			// whatever the output enable pin says.
			r_next.wr_seen = en_now && wr_any;
			// Output stage loads from the array stage every edge.
			// Its valid bit marks a read that left the array stage.
			r_next.out_vld  = r_reg.rd_pend;
			r_next.out_data = mem_arr[r_reg.addr];
			r_next.rd_pend  = 1'b0;
			if (strobe && sel_ok) begin
				// New access: latch the address, read unless writing.
				// Address pins are looked at here and for wr_addr, only at a selected strobe.
				r_next.addr    = pins.addr;
				r_next.rd_pend = !do_wr;
			end else if (en_now && !pins.burst_advance_n) begin
				// Burst step: linear count in the low address bits.
				// Only the low bits wrap, so the burst stays in its block.
				r_next.addr[ssr_pkg::BURST_W-1:0] =
					r_reg.addr[ssr_pkg::BURST_W-1:0] + 1'b1;
				r_next.rd_pend = !do_wr;
			end
		end
	end

	// State register with asynchronous reset.
	// Reset leaves the device awake, deselected and with nothing pending.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r_reg.pwr      <= ssr_pkg::SSR_AWAKE;
			r_reg.cnt      <= ssr_pkg::CNT_RST;
			r_reg.enabled  <= 1'b0;
			r_reg.addr     <= '0;
			r_reg.rd_pend  <= 1'b0;
			r_reg.out_vld  <= 1'b0;
			r_reg.wr_seen  <= 1'b0;
			r_reg.out_data <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// Array write port, lane by lane; storage itself has no reset.
	// Write data comes from the resolved wire that the controller drives.
	always_ff @(posedge ref_clk_i) begin
		for (int i = 0; i < NL; i++) begin
			if (do_wr && lane_we[i]) begin
				mem_arr[wr_addr][i*LW +: LW] <= pins.dq[i*LW +: LW];
			end
		end
	end

	// Read data drives only when awake, enabled by output enable, and
	// no write was sampled; the enable is a don't care for writes.
	// The data word always comes from the output stage register.
	assign pins.mem_dq    = r_reg.out_data;
	assign pins.mem_dq_oe = r_reg.out_vld && !pins.output_enable_n &&
		!r_reg.wr_seen && !asleep;
	// Status for the system: snooze or waking, and present selection.
	assign snoozing_o     = asleep;
	assign enabled_o      = r_reg.enabled;
endmodule
`default_nettype wire

// >>> ssr_ctl_end.sv
// Controller end: single-word reads and writes plus snooze handling.
`timescale 1ns/1ps
`default_nettype none
module ssr_ctl_end #(
	parameter int unsigned AW = ssr_pkg::ADDR_W,
	parameter int unsigned NL = ssr_pkg::LANES,
	parameter int unsigned LW = ssr_pkg::LANE_W
) (
	input  wire logic          ref_clk_i,   // System clock.
	input  wire logic          rst_n_i,     // Asynchronous reset, active low.
	ssr_if.ctl                 pins,        // Pin side toward the memory.
	input  wire logic          req_valid_i, // Access request.
	input  wire logic          req_write_i, // High for write.
	input  wire logic [AW-1:0] req_addr_i,  // Word address.
	input  wire logic [NL*LW-1:0] req_wdata_i, // Write data.
	input  wire logic [NL-1:0] req_lanes_i, // Lanes to write.
	output logic               req_ready_o, // Request taken when high.
	output logic               rd_valid_o,  // One-cycle read data pulse.
	output logic [NL*LW-1:0]   rd_data_o,   // Read data.
	input  wire logic          sleep_i,     // Level asking for snooze.
	output logic               asleep_o     // High in snooze or recovery.
);
	localparam int unsigned DW = NL * LW;

	// Whole register state of the controller.
	typedef struct packed {
		ssr_pkg::ssr_ctl_st_t      st;      // Controller state.
		logic [ssr_pkg::CNT_W-1:0] cnt;     // Recovery countdown.
		logic                      strb_n;  // Controller strobe pin.
		logic                      sel;     // Selects asserted.
		logic                      oe_n;    // Output enable pin.
		logic                      gate_n;  // Lane write gate pin.
		logic [NL-1:0]             bw_n;    // Lane strobes.
		logic [AW-1:0]             addr;    // Address pins.
		logic [DW-1:0]             wdata;   // Data pins.
		logic                      dq_oe;   // Drive data pins.
		logic                      sleep;   // Sleep pin.
		logic                      rd_vld;  // Read result pulse.
		logic [DW-1:0]             rdata;   // Read result.
	} ssr_ctl_reg_t;

	ssr_ctl_reg_t r_reg;                    // Registered state.
	ssr_ctl_reg_t r_next;                   // Next state.

	// Next-state logic; pins change only from registered fields.
	always_comb begin
		r_next        = r_reg;
		r_next.rd_vld = 1'b0;
		r_next.strb_n = 1'b1;
		r_next.gate_n = 1'b1;
		r_next.bw_n   = '1;
		r_next.dq_oe  = 1'b0;
		case (r_reg.st)
			ssr_pkg::SSR_IDLE: begin
				r_next.sel  = 1'b0;
				r_next.oe_n = 1'b1;
				if (sleep_i) begin
					// Selects are already inactive when idle.
					r_next.st    = ssr_pkg::SSR_SLEEP;
					r_next.sleep = 1'b1;
				end else if (req_valid_i) begin
					r_next.strb_n = 1'b0;
					r_next.sel    = 1'b1;
					r_next.addr   = req_addr_i;
					if (req_write_i) begin
						r_next.st    = ssr_pkg::SSR_WR;
						r_next.gate_n = 1'b0;
						r_next.bw_n  = ~req_lanes_i;
						r_next.wdata = req_wdata_i;
						r_next.dq_oe = 1'b1;
					end else begin
						r_next.st = ssr_pkg::SSR_RD_ADDR;
					end
				end
			end
			ssr_pkg::SSR_RD_ADDR: begin
				// Address taken by the memory on this edge.
				r_next.sel  = 1'b0;
				r_next.oe_n = 1'b0;
				r_next.st   = ssr_pkg::SSR_RD_WAIT;
			end
			ssr_pkg::SSR_RD_WAIT: begin
				r_next.st = ssr_pkg::SSR_RD_CAPT;
			end
			ssr_pkg::SSR_RD_CAPT: begin
				// Pipelined data is on the wire now.
				r_next.rdata  = pins.dq;
				r_next.rd_vld = 1'b1;
				r_next.oe_n   = 1'b1;
				r_next.st     = ssr_pkg::SSR_IDLE;
			end
			ssr_pkg::SSR_WR: begin
				r_next.sel = 1'b0;
				r_next.st  = ssr_pkg::SSR_IDLE;
			end
			ssr_pkg::SSR_SLEEP: begin
				if (!sleep_i) begin
					r_next.sleep = 1'b0;
					r_next.cnt   = ssr_pkg::CNT_W'(ssr_pkg::SLEEP_RECOVERY_CYC - 1);
					r_next.st    = ssr_pkg::SSR_RECOVER;
				end
			end
			ssr_pkg::SSR_RECOVER: begin
				// Selects and strobes stay inactive for the recovery time.
				if (r_reg.cnt == ssr_pkg::CNT_RST) begin
					r_next.st = ssr_pkg::SSR_IDLE;
				end else begin
					r_next.cnt = r_reg.cnt - 1'b1;
				end
			end
			default: begin
				r_next.st = ssr_pkg::SSR_IDLE;
			end
		endcase
	end

	// State register with asynchronous reset.
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r_reg.st     <= ssr_pkg::SSR_IDLE;
			r_reg.cnt    <= ssr_pkg::CNT_RST;
			r_reg.strb_n <= 1'b1;
			r_reg.sel    <= 1'b0;
			r_reg.oe_n   <= 1'b1;
			r_reg.gate_n <= 1'b1;
			r_reg.bw_n   <= '1;
			r_reg.addr   <= '0;
			r_reg.wdata  <= '0;
			r_reg.dq_oe  <= 1'b0;
			r_reg.sleep  <= 1'b0;
			r_reg.rd_vld <= 1'b0;
			r_reg.rdata  <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	// Pin and user outputs from registered state, except req_ready_o, which also gates on sleep_i.
	assign pins.sleep_request               = r_reg.sleep;
	assign pins.processor_address_strobe_n  = 1'b1;
	assign pins.controller_address_strobe_n = r_reg.strb_n;
	assign pins.burst_advance_n             = 1'b1;
	assign pins.global_write_strobe_n       = 1'b1;
	assign pins.byte_write_gate_n           = r_reg.gate_n;
	assign pins.byte_lane_write_n           = r_reg.bw_n;
	assign pins.chip_select_n               = !r_reg.sel;
	assign pins.chip_select_high            = r_reg.sel;
	assign pins.chip_select_b_n             = !r_reg.sel;
	assign pins.output_enable_n             = r_reg.oe_n;
	assign pins.addr                        = r_reg.addr;
	assign pins.ctl_dq                      = r_reg.wdata;
	assign pins.ctl_dq_oe                   = r_reg.dq_oe;
	assign req_ready_o = (r_reg.st == ssr_pkg::SSR_IDLE) && !sleep_i;
	assign rd_valid_o  = r_reg.rd_vld;
	assign rd_data_o   = r_reg.rdata;
	assign asleep_o    = r_reg.sleep || (r_reg.st == ssr_pkg::SSR_RECOVER);
endmodule
`default_nettype wire

// >>> ssr_link_checker.sv
// Concurrent checks on the pins between the two SRAM ends.
`timescale 1ns/1ps
`default_nettype none
module ssr_link_checker #(
	parameter int unsigned AW = ssr_pkg::ADDR_W,
	parameter int unsigned NL = ssr_pkg::LANES,
	parameter int unsigned LW = ssr_pkg::LANE_W
) (
	input wire logic          ref_clk_i,
	input wire logic          rst_n_i,
	input wire logic          sleep_request,
	input wire logic          processor_address_strobe_n,
	input wire logic          controller_address_strobe_n,
	input wire logic          global_write_strobe_n,
	input wire logic          byte_write_gate_n,
	input wire logic [NL-1:0] byte_lane_write_n,
	input wire logic          chip_select_n,
	input wire logic          chip_select_high,
	input wire logic          chip_select_b_n,
	input wire logic          output_enable_n,
	input wire logic          ctl_dq_oe,
	input wire logic          mem_dq_oe
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// A write is seen when a global or gated lane strobe is low.
	wire logic wr_seen = !global_write_strobe_n ||
		(!byte_write_gate_n && !(&byte_lane_write_n));
	// All three selects in their active state.
	wire logic sel = !chip_select_n && chip_select_high && !chip_select_b_n;
	// A read start that the memory end must capture.
	wire logic rd_go = !controller_address_strobe_n && sel && !wr_seen &&
		!sleep_request;

	a_snooze_no_drive: assert property (sleep_request |-> !mem_dq_oe)
		else $error("Memory drives data while snooze is asked.");
	a_deselect_before_sleep: assert property ($rose(sleep_request) |->
		chip_select_n && $past(chip_select_n))
		else $error("Sleep raised while the device was selected.");
	a_recovery_quiet: assert property ($fell(sleep_request) |->
		(chip_select_n && controller_address_strobe_n &&
		processor_address_strobe_n)[*2])
		else $error("Select or strobe active during recovery.");
	a_waking_no_drive: assert property ($fell(sleep_request) |->
		!mem_dq_oe[*3])
		else $error("Memory drove data before recovery ended.");
	a_oe_after_write: assert property (wr_seen |=> !mem_dq_oe)
		else $error("Output drove after a sampled write.");
	a_read_pipeline: assert property (rd_go |-> ##2 mem_dq_oe)
		else $error("Read data missing two edges after capture.");
	a_strobe_selects: assert property (!controller_address_strobe_n |->
		sel)
		else $error("Strobe issued without valid selects.");
	a_drive_needs_oe: assert property (mem_dq_oe |->
		!output_enable_n && $past(!wr_seen))
		else $error("Memory drove data with output enable off.");
	a_no_clash: assert property (!(mem_dq_oe && ctl_dq_oe))
		else $error("Both ends drive the data wire.");
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench joining both SRAM ends through their pin bundle.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int unsigned AW = ssr_pkg::ADDR_W; // Address width.
	localparam int unsigned LW = ssr_pkg::LANE_W; // Lane width.
	localparam int unsigned DW = ssr_pkg::LANES * LW; // Word width.
	logic          ref_clk_i;   // Clock.
	logic          rst_n_i;     // Reset, active low.
	logic          req_valid;   // Request strobe.
	logic          req_write;   // High for write.
	logic [AW-1:0] req_addr;    // Request address.
	logic [DW-1:0] req_wdata;   // Write data.
	logic [3:0]    req_lanes;   // Lanes to write.
	logic          req_ready;   // Request taken.
	logic          rd_valid;    // Read data pulse.
	logic [DW-1:0] rd_data;     // Read data.
	logic          sleep;       // Snooze level.
	logic          asleep;      // Controller asleep.
	logic          snoozing;    // Memory in snooze.
	logic          enabled;     // Memory selected.
	logic [DW-1:0] exp_w;       // Expected merged word.
	int            err_count;   // Mismatches.
	int            total_checks; // Comparisons.
	int            n;           // Cycle counter.

	ssr_if u_ssr_if ();
	ssr_mem_end u_ssr_mem_end (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.pins(u_ssr_if.mem), .snoozing_o(snoozing), .enabled_o(enabled));
	ssr_ctl_end u_ssr_ctl_end (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.pins(u_ssr_if.ctl), .req_valid_i(req_valid),
		.req_write_i(req_write), .req_addr_i(req_addr),
		.req_wdata_i(req_wdata), .req_lanes_i(req_lanes),
		.req_ready_o(req_ready), .rd_valid_o(rd_valid),
		.rd_data_o(rd_data), .sleep_i(sleep), .asleep_o(asleep));
	ssr_link_checker u_ssr_link_checker (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .sleep_request(u_ssr_if.sleep_request),
		.processor_address_strobe_n(u_ssr_if.processor_address_strobe_n),
		.controller_address_strobe_n(u_ssr_if.controller_address_strobe_n),
		.global_write_strobe_n(u_ssr_if.global_write_strobe_n),
		.byte_write_gate_n(u_ssr_if.byte_write_gate_n),
		.byte_lane_write_n(u_ssr_if.byte_lane_write_n),
		.chip_select_n(u_ssr_if.chip_select_n),
		.chip_select_high(u_ssr_if.chip_select_high),
		.chip_select_b_n(u_ssr_if.chip_select_b_n),
		.output_enable_n(u_ssr_if.output_enable_n),
		.ctl_dq_oe(u_ssr_if.ctl_dq_oe), .mem_dq_oe(u_ssr_if.mem_dq_oe));

	// Free-running 50 MHz clock.
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	// Prints the counts and the verdict, then stops the run.
	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Compares a data word or a count.
	task automatic check_word(input logic [DW-1:0] got,
		input logic [DW-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Compares a single flag.
	task automatic check_flag(input logic got, input logic exp);
		check_word(DW'(got), DW'(exp));
	endtask

	// Counts a spent bound as a mismatch and ends the run.
	task automatic bound(input int lim);
		n++;
		if (n > lim) begin
			err_count++;
			print_verdict();
		end
	endtask

	// Waits until the controller is ready, then presents one request for one cycle.
	task automatic access(input logic wr, input logic [AW-1:0] a,
		input logic [DW-1:0] d, input logic [3:0] ln);
		n = 0;
		@(negedge ref_clk_i);
		while (req_ready !== 1'b1) begin
			@(negedge ref_clk_i);
			bound(50);
		end
		req_valid = 1'b1;
		req_write = wr;
		req_addr = a;
		req_wdata = d;
		req_lanes = ln;
		@(negedge ref_clk_i);
		req_valid = 1'b0;
	endtask

	// Reads one word and checks its value and its answer latency.
	task automatic read_word(input logic [AW-1:0] a, input logic [DW-1:0] e);
		access(1'b0, a, '0, 4'h0);
		n = 1;
		while (rd_valid !== 1'b1) begin
			@(negedge ref_clk_i);
			bound(8);
		end
		check_word(DW'(n), DW'(4));
		check_word(rd_data, e);
	endtask

	// Main sequence.
	initial begin
		err_count = 0;
		total_checks = 0;
		rst_n_i = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		req_wdata = '0;
		req_lanes = 4'h0;
		sleep = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		// Top address, full word, then back-to-back read.
		access(1'b1, 17'h1ffff, 36'h987654321, 4'hf);
		read_word(17'h1ffff, 36'h987654321);
		check_flag(enabled, 1'b1);
		// Each lane alone over a cleared word.
		exp_w = 36'h0;
		access(1'b1, 17'h00005, exp_w, 4'hf);
		for (int i = 0; i < 4; i++) begin
			exp_w[i*LW +: LW] = LW'(9'h0a0 + i);
			access(1'b1, 17'h00005, {4{LW'(9'h0a0 + i)}}, 4'h1 << i);
			read_word(17'h00005, exp_w);
		end
		// Snooze: requests refused, contents kept.
		sleep = 1'b1;
		n = 0;
		@(negedge ref_clk_i);
		check_flag(req_ready, 1'b0);
		while (u_ssr_if.sleep_request !== 1'b1) begin
			@(negedge ref_clk_i);
			bound(ssr_pkg::SLEEP_ENTRY_CYC);
		end
		check_flag(snoozing, 1'b1);
		req_valid = 1'b1;
		req_write = 1'b1;
		req_addr = 17'h00005;
		req_wdata = ~exp_w;
		req_lanes = 4'hf;
		repeat (5) @(negedge ref_clk_i);
		check_flag(asleep, 1'b1);
		check_flag(enabled, 1'b0);
		req_valid = 1'b0;
		@(negedge ref_clk_i);
		sleep = 1'b0;
		n = 0;
		while (req_ready !== 1'b1) begin
			@(negedge ref_clk_i);
			bound(10);
		end
		check_flag(n >= ssr_pkg::SLEEP_RECOVERY_CYC, 1'b1);
		read_word(17'h00005, exp_w);
		check_flag(snoozing, 1'b0);
		read_word(17'h1ffff, 36'h987654321);
		print_verdict();
	end
endmodule
`default_nettype wire
